// >>> rmes_host_model.sv
// Far-side model: board reset source and external programming host.
// Assumes its tasks are called by the bench just after a clock edge.
`timescale 1ns/1ps
module rmes_host_model (
   input  wire logic i_clk_sys,
   output logic      o_rst_pin,
   output logic      o_program_store_strobe_n
);
   initial begin
      o_rst_pin                = 1'b0;
      o_program_store_strobe_n = 1'b1;
   end

   task automatic drive_reset(input int n);
      o_rst_pin = 1'b1;
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic release_reset();
      o_rst_pin = 1'b0;
   endtask

   task automatic strobe_fall();
      o_program_store_strobe_n = 1'b0;
      repeat (6) @(posedge i_clk_sys);
      #1;
      o_program_store_strobe_n = 1'b1;
   endtask
endmodule // rmes_host_model

// >>> rmes_pkg.sv
// Package of constants and types for the reset and mode entry sequencer.
// Assumes a single system clock that stands for the oscillator clock.
package rmes_pkg;
   // ==========================================================================
   // Machine cycle timing
   // ==========================================================================
   localparam int unsigned STATES_PER_CYCLE = 6;
   localparam int unsigned PHASES_PER_STATE = 2;
   localparam int unsigned CLKS_PER_CYCLE   = STATES_PER_CYCLE * PHASES_PER_STATE;
   localparam int unsigned RESET_MIN_CYCLES = 2;
   localparam int unsigned RESET_MIN_CLKS   = RESET_MIN_CYCLES * CLKS_PER_CYCLE;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [15:0] RESET_PC       = 16'h0000;
   localparam logic [7:0]  PORT_RESET     = 8'hFF;
   localparam int unsigned NUM_PORTS      = 4;
   localparam int unsigned SFR_COUNT      = 8;
   localparam logic [7:0]  SFR_RESET_VAL  = 8'h00;
   localparam int unsigned RAM_DEPTH      = 256;

   // ==========================================================================
   // Sequencer states
   // ==========================================================================
   typedef enum logic [4:0] {
      RMES_ST_POWERUP = 5'h01,
      RMES_ST_RESET   = 5'h02,
      RMES_ST_WAIT    = 5'h04,
      RMES_ST_HOST    = 5'h08,
      RMES_ST_IAP     = 5'h10
   } rmes_state_type;
endpackage : rmes_pkg

// >>> rmes_sequencer.sv
// Reset and mode entry sequencer: machine-cycle timing, reset qualification,
// strobe forcing, default loading and programming mode selection.
// Assumes the reset pin and the program-store strobe pin arrive asynchronously.
`timescale 1ns/1ps

// Operation
// - Each machine cycle is six states of two one-clock phases, twelve clocks in all.
// - After a reset that does not enter host programming the processor starts fetching at address zero.
// - While reset is active the program-store strobe is pulled high.
// - A running reset leaves the 256-byte data RAM unchanged.
// - Reset loads every special function register with its default.
// - A falling strobe while reset is still held after completion selects host programming.
// - Without that strobe edge the device enters in-application programming mode.
// - Reset writes ones to all port latches.
module rmes_sequencer #(
   parameter int unsigned RESET_CLKS = rmes_pkg::RESET_MIN_CLKS
) (
   input  wire logic                               i_clk_sys,
   input  wire logic                               i_reset,
   input  wire logic                               i_rst_pin,
   input  wire logic                               i_program_store_strobe_n,
   input  wire logic                               i_ram_we,
   input  wire logic [7:0]                         i_ram_addr,
   input  wire logic [7:0]                         i_ram_wdata,
   output logic      [7:0]                         o_ram_rdata,
   output logic                                    o_strobe_pullup,
   output logic                                    o_core_reset,
   output logic      [15:0]                        o_fetch_addr,
   output logic                                    o_fetch_start,
   output logic      [3:0]                         o_machine_state,
   output logic                                    o_phase,
   output logic                                    o_cycle_tick,
   output logic      [rmes_pkg::NUM_PORTS*8-1:0]   o_port_latch,
   output logic      [rmes_pkg::SFR_COUNT*8-1:0]   o_sfr,
   output logic                                    o_host_mode,
   output logic                                    o_in_application_programming_mode
);
   import rmes_pkg::*;

   // The qualification counter is eight bits wide and saturates at the limit.
   if (RESET_CLKS < 2 || RESET_CLKS > 255) begin : g_bad_reset_clks
      $error("RESET_CLKS out of range");
   end

   // ==========================================================================
   // Input synchronisers
   // ==========================================================================
   logic [2:0] rst_sync;
   logic [2:0] strb_sync;
   logic       rst_level;
   logic       strb_level;
   logic       strb_fall;

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         rst_sync  <= 3'h0;
         strb_sync <= 3'h7;
      end else begin
         rst_sync  <= {rst_sync[1:0], i_rst_pin};
         strb_sync <= {strb_sync[1:0], i_program_store_strobe_n};
      end
   end

   // A change counts once the second and third stages agree.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         rst_level  <= 1'b0;
         strb_level <= 1'b1;
      end else begin
         if (rst_sync[1] == rst_sync[2]) begin
            rst_level <= rst_sync[2];
         end
         if (strb_sync[1] == strb_sync[2]) begin
            strb_level <= strb_sync[2];
         end
      end
   end

   logic strb_level_d;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         strb_level_d <= 1'b1;
      end else begin
         strb_level_d <= strb_level;
      end
   end
   assign strb_fall = strb_level_d & ~strb_level;

   // ==========================================================================
   // Machine cycle timing
   // ==========================================================================
   logic [3:0] clk_in_cycle;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || o_core_reset) begin
         clk_in_cycle <= 4'h0;
      end else if (clk_in_cycle == 4'(CLKS_PER_CYCLE - 1)) begin
         clk_in_cycle <= 4'h0;
      end else begin
         clk_in_cycle <= clk_in_cycle + 4'h1;
      end
   end
   assign o_machine_state = 4'(clk_in_cycle >> 1) + 4'h1;
   assign o_phase         = clk_in_cycle[0];
   assign o_cycle_tick    = (clk_in_cycle == 4'(CLKS_PER_CYCLE - 1));

   // ==========================================================================
   // Reset qualification
   // ==========================================================================
   logic [7:0] high_count;
   logic       qualified;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || !rst_level) begin
         high_count <= 8'h00;
      end else if (high_count != 8'(RESET_CLKS)) begin
         high_count <= high_count + 8'h01;
      end
   end
   assign qualified = (high_count == 8'(RESET_CLKS));

   // ==========================================================================
   // Sequencer
   // ==========================================================================
   rmes_state_type state;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state <= RMES_ST_POWERUP;
      end else begin
         unique case (state)
            RMES_ST_POWERUP, RMES_ST_HOST, RMES_ST_IAP: begin
               if (qualified && state != RMES_ST_HOST) begin
                  state <= RMES_ST_RESET;
               end
               if (state == RMES_ST_HOST && !rst_level) begin
                  state <= RMES_ST_IAP;
               end
            end
            RMES_ST_RESET: begin
               state <= RMES_ST_WAIT;
            end
            RMES_ST_WAIT: begin
               if (rst_level && strb_fall) begin
                  state <= RMES_ST_HOST;
               end else if (!rst_level) begin
                  state <= RMES_ST_IAP;
               end
            end
            default: begin
               state <= RMES_ST_POWERUP;
            end
         endcase
      end
   end

   logic in_reset;
   assign in_reset = (state == RMES_ST_POWERUP) || (state == RMES_ST_RESET) || (state == RMES_ST_WAIT);
   assign o_strobe_pullup = in_reset;
   assign o_core_reset    = in_reset;
   assign o_host_mode     = (state == RMES_ST_HOST);
   assign o_in_application_programming_mode = (state == RMES_ST_IAP);

   // ==========================================================================
   // Reset defaults
   // ==========================================================================
   // fetch from zero
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_fetch_addr  <= RESET_PC;
         o_fetch_start <= 1'b0;
      end else begin
         o_fetch_addr  <= RESET_PC;
         o_fetch_start <= (state == RMES_ST_WAIT) && !rst_level;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || state == RMES_ST_RESET) begin
         o_port_latch <= {NUM_PORTS{PORT_RESET}};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || state == RMES_ST_RESET) begin
         o_sfr <= {SFR_COUNT{SFR_RESET_VAL}};
      end
   end

   // ==========================================================================
   // On-chip data RAM
   // ==========================================================================
   logic [7:0] ram [RAM_DEPTH];
   logic       ram_write;
   logic       last_wr_valid;
   logic [7:0] last_wr_addr;
   logic [7:0] last_wr_data;
   assign ram_write = i_ram_we && !in_reset;
   always_ff @(posedge i_clk_sys) begin
      if (ram_write) begin
         ram[i_ram_addr] <= i_ram_wdata;
      end
   end
   // The last accepted write gives the retention check a known value to expect.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         last_wr_valid <= 1'b0;
         last_wr_addr  <= 8'h00;
         last_wr_data  <= 8'h00;
      end else if (ram_write) begin
         last_wr_valid <= 1'b1;
         last_wr_addr  <= i_ram_addr;
         last_wr_data  <= i_ram_wdata;
      end
   end
   always_ff @(posedge i_clk_sys) begin
      o_ram_rdata <= ram[i_ram_addr];
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   property p_cycle_len;
      @(posedge i_clk_sys) disable iff (i_reset || o_core_reset)
      o_cycle_tick |=> !o_cycle_tick [*8] ##1 !o_cycle_tick [*3] ##1 o_cycle_tick;
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("machine cycle not twelve clocks");

   property p_qualify;
      @(posedge i_clk_sys) disable iff (i_reset)
      $rose(qualified) |-> $past(rst_level, 1) && $past(high_count, 1) == 8'(RESET_CLKS - 1);
   endproperty
   a_qualify: assert property (p_qualify) else $error("reset qualified without high run");

   property p_strobe;
      @(posedge i_clk_sys) disable iff (i_reset)
      $rose(qualified) |=> o_strobe_pullup [*2];
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobes not high in reset");

   property p_ports;
      @(posedge i_clk_sys) disable iff (i_reset)
      (state == RMES_ST_RESET) |=> o_port_latch == {NUM_PORTS{PORT_RESET}} && o_sfr == {SFR_COUNT{SFR_RESET_VAL}};
   endproperty
   a_ports: assert property (p_ports) else $error("defaults not loaded");

   property p_host;
      @(posedge i_clk_sys) disable iff (i_reset)
      (state == RMES_ST_WAIT && rst_level && strb_fall) |=> o_host_mode;
   endproperty
   a_host: assert property (p_host) else $error("host mode missed");

   property p_iap;
      @(posedge i_clk_sys) disable iff (i_reset)
      (state == RMES_ST_WAIT && !rst_level) |=> o_in_application_programming_mode && o_fetch_start ##1 !o_fetch_start;
   endproperty
   a_iap: assert property (p_iap) else $error("application mode missed");

   property p_fetch;
      @(posedge i_clk_sys) disable iff (i_reset)
      o_fetch_start |-> o_fetch_addr == RESET_PC && o_in_application_programming_mode;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch not from zero");

   property p_ram;
      @(posedge i_clk_sys) disable iff (i_reset)
      in_reset && last_wr_valid && i_ram_addr == last_wr_addr |=> o_ram_rdata == last_wr_data;
   endproperty
   a_ram: assert property (p_ram) else $error("RAM changed in reset");

   c_host: cover property (@(posedge i_clk_sys) disable iff (i_reset) $rose(o_host_mode));
   c_iap: cover property (@(posedge i_clk_sys) disable iff (i_reset) $rose(o_in_application_programming_mode));
   c_abort: cover property (@(posedge i_clk_sys) disable iff (i_reset) rst_level ##1 !rst_level && !qualified);
endmodule // rmes_sequencer

// >>> test_reset_and_mode_entry_sequencer.sv
// Self-checking bench for the reset and mode entry sequencer.
// Assumes the host model drives the reset and strobe pins.
`timescale 1ns/1ps
module test_reset_and_mode_entry_sequencer;
   import rmes_pkg::*;
   logic        clk, rst, we, rpin, strb, pull, core, fst, phase, tick, hostm, in_application_programming_mode;
   logic [7:0]  addr, wdata, rdata;
   logic [15:0] faddr;
   logic [3:0]  mst;
   logic [31:0] ports;
   logic [63:0] special_function_registers;
   int          mismatches, comparisons, starts, n;
   int          hold [4] = '{8, 20, 34, 60};
   logic        expr [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

   rmes_host_model host (.i_clk_sys(clk), .o_rst_pin(rpin), .o_program_store_strobe_n(strb));
   rmes_sequencer dut (.i_clk_sys(clk), .i_reset(rst), .i_rst_pin(rpin),
      .i_program_store_strobe_n(strb), .i_ram_we(we), .i_ram_addr(addr), .i_ram_wdata(wdata),
      .o_ram_rdata(rdata), .o_strobe_pullup(pull), .o_core_reset(core), .o_fetch_addr(faddr),
      .o_fetch_start(fst), .o_machine_state(mst), .o_phase(phase), .o_cycle_tick(tick),
      .o_port_latch(ports), .o_sfr(special_function_registers), .o_host_mode(hostm), .o_in_application_programming_mode(in_application_programming_mode));

   // ==========================================================================
   // Clock, watchdog and reporting
   // ==========================================================================
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #1000000;
      mismatches++;
      final_report();
   end
   always @(negedge clk) if (fst === 1'b1) starts++;

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      if (mismatches == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic settle_iap(input int s0);
      host.release_reset();
      repeat (12) @(posedge clk);
      #1;
      check("iap", in_application_programming_mode, 1'b1);
      check("core", core, 1'b0);
      check("starts", starts - s0, 1);
      check("faddr", faddr, RESET_PC);
      check("ports", ports, {NUM_PORTS{PORT_RESET}});
      check("sfr", special_function_registers, {SFR_COUNT{SFR_RESET_VAL}});
   endtask

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      rst = 1'b1; we = 1'b0; addr = 8'h00; wdata = 8'h00;
      repeat (5) @(posedge clk);
      #1;
      check("rst core", core, 1'b1);
      check("rst pull", pull, 1'b1);
      check("rst ports", ports, {NUM_PORTS{PORT_RESET}});
      rst = 1'b0;
      host.drive_reset(34);
      settle_iap(starts);
      for (int i = 0; i < 4; i++) begin
         n = starts;
         host.drive_reset(hold[i]);
         check("row core", core, expr[i]);
         check("row pull", pull, expr[i]);
         if (expr[i]) settle_iap(n);
         else host.release_reset();
         repeat (4) @(posedge clk);
         #1;
      end
      host.drive_reset(15);
      host.release_reset();
      repeat (2) @(posedge clk);
      #1;
      host.drive_reset(15);
      check("restart", core, 1'b0);
      host.release_reset();
      we = 1'b1; addr = 8'h5A; wdata = 8'hC3;
      @(posedge clk);
      #1;
      we = 1'b0;
      host.drive_reset(34);
      settle_iap(starts);
      repeat (2) @(posedge clk);
      #1;
      check("ram", rdata, 8'hC3);
      host.drive_reset(34);
      host.strobe_fall();
      repeat (4) @(posedge clk);
      #1;
      check("host", hostm, 1'b1);
      check("host iap", in_application_programming_mode, 1'b0);
      host.release_reset();
      repeat (12) @(posedge clk);
      #1;
      check("exit", in_application_programming_mode, 1'b1);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (tick !== 1'b1 && n < 40);
      end
      check("cycle", n, CLKS_PER_CYCLE);
      check("state", mst, STATES_PER_CYCLE);
      check("phase", phase, 1'b1);
      @(posedge clk);
      #1;
      check("wrap", {mst, phase}, {4'h1, 1'b0});
      final_report();
   end
endmodule // test_reset_and_mode_entry_sequencer
